//--- src/rsab_top.sv
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module rsab_top
#(
   parameter int BKP_WORDS = rsab_pkg::BKP_NUM,
   parameter int TAMPER_INPUTS = rsab_pkg::TAMPER_NUM
)
(
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire logic i_backup_reset,
   input wire rsab_pkg::rsab_bus_req_type i_bus,
   output logic [rsab_pkg::DATA_W-1:0] o_rdata,
   input wire logic [rsab_pkg::CNT_W-1:0] i_subsecond_sync_counter,
   input wire logic i_second_tick,
   input wire logic [rsab_pkg::ALARM_NUM-1:0] i_fields_match,
   output logic [rsab_pkg::ALARM_NUM-1:0] o_alarm_match,
   input wire logic [TAMPER_INPUTS-1:0] i_tamper_event,
   input wire logic [TAMPER_INPUTS-1:0] i_tamper_no_erase,
   output logic o_alarm_pin_out,
   output logic o_alarm_pin_oe,
   output logic o_irq
);

   ////////////////////////////////////////////////////////////////////
   // Decode helpers

   function automatic logic reg_hit
   (
      input logic [rsab_pkg::ADDR_W-1:0] addr,
      input logic [rsab_pkg::ADDR_W-1:0] ofs
   );
      reg_hit = (addr == ofs);
   endfunction

   // Mask of the low n bits; n of zero gives no bits
   function automatic logic [rsab_pkg::SS_W-1:0] ss_mask
   (
      input logic [rsab_pkg::MASK_W-1:0] n
   );
      logic [15:0] full;
      full = 16'hFFFF >> (5'h10 - {1'b0, n});
      ss_mask = full[rsab_pkg::SS_W-1:0];
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Address decode

   wire logic wr_en;
   wire logic rd_en;
   wire logic sel_option;
   wire logic sel_status;
   wire logic sel_clear;
   wire logic sel_enable;
   wire logic sel_bkp;
   wire logic [rsab_pkg::ADDR_W-1:0] bkp_off;
   wire logic [rsab_pkg::IDX_W-1:0] bkp_idx;

   assign wr_en = i_bus.wr;
   assign rd_en = i_bus.rd;
   assign sel_option = reg_hit(i_bus.addr, rsab_pkg::OFS_OPTION);
   assign sel_status = reg_hit(i_bus.addr, rsab_pkg::OFS_STATUS);
   assign sel_clear = reg_hit(i_bus.addr, rsab_pkg::OFS_CLEAR);
   assign sel_enable = reg_hit(i_bus.addr, rsab_pkg::OFS_ENABLE);
   assign bkp_off = i_bus.addr - rsab_pkg::OFS_BKP_FIRST;
   assign bkp_idx = bkp_off[6:2];
   assign sel_bkp = (i_bus.addr >= rsab_pkg::OFS_BKP_FIRST)
                 && (i_bus.addr <= rsab_pkg::OFS_BKP_LAST)
                 && (i_bus.addr[1:0] == 2'h0)
                 && (32'(bkp_idx) < BKP_WORDS);

   ////////////////////////////////////////////////////////////////////
   // Sub-second alarm comparators

   logic [rsab_pkg::DATA_W-1:0] alarm_rd [0:rsab_pkg::ALARM_NUM-1];
   logic [rsab_pkg::ALARM_NUM-1:0] alarm_hit;
   logic [rsab_pkg::MASK_W-1:0] alarm_mask [0:rsab_pkg::ALARM_NUM-1];

   genvar ga;
   generate
      for (ga = 0; ga < rsab_pkg::ALARM_NUM; ga++)
      begin : gen_alarm
         rsab_pkg::rsab_alarm_ss_type alarm_reg;
         logic cond_prev_reg;
         logic pulse_reg;
         wire logic sel;
         wire logic ss_hit;
         wire logic cond;
         wire logic [rsab_pkg::ADDR_W-1:0] ofs;

         assign ofs = (ga == 0) ? rsab_pkg::OFS_ALARM_A : rsab_pkg::OFS_ALARM_B;
         assign sel = reg_hit(i_bus.addr, ofs);
         // Only the low fifteen counter bits reach the compare
         assign ss_hit = ((i_subsecond_sync_counter[rsab_pkg::SSV_MSB:0]
                          ^ alarm_reg.match_value)
                          & ss_mask(alarm_reg.mask_count)) == 15'h0000;
         assign cond = (alarm_reg.mask_count == rsab_pkg::MASK_RESET)
                     ? (i_second_tick && i_fields_match[ga])
                     : (ss_hit && i_fields_match[ga]);
         // A match holds for a whole prescaler step; flag only its start
         assign alarm_hit[ga] = cond && !cond_prev_reg;
         assign o_alarm_match[ga] = pulse_reg;
         assign alarm_mask[ga] = alarm_reg.mask_count;
         // Reserved bits are not stored and read back as zero
         assign alarm_rd[ga] = {4'h0, alarm_reg.mask_count, 9'h000, alarm_reg.match_value};

         always_ff @(posedge i_ref_clk or posedge i_reset)
         begin
            if (i_reset)
            begin
               alarm_reg <= {rsab_pkg::MASK_RESET, rsab_pkg::SSV_RESET};
               cond_prev_reg <= 1'b0;
               pulse_reg <= 1'b0;
            end
            else
            begin
               if (wr_en && sel)
               begin
                  alarm_reg <= {i_bus.wdata[rsab_pkg::MASK_MSB:rsab_pkg::MASK_LSB],
                                i_bus.wdata[rsab_pkg::SSV_MSB:0]};
               end
               cond_prev_reg <= cond;
               pulse_reg <= alarm_hit[ga];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // Backup words, held in the backup power domain

   logic [rsab_pkg::DATA_W-1:0] bkp_word [0:BKP_WORDS-1];
   wire logic tamper_erase;

   assign tamper_erase = |(i_tamper_event & ~i_tamper_no_erase);

   genvar gb;
   generate
      for (gb = 0; gb < BKP_WORDS; gb++)
      begin : gen_bkp
         logic [rsab_pkg::DATA_W-1:0] word_reg;
         wire logic wr_sel;

         assign wr_sel = wr_en && sel_bkp && (32'(bkp_idx) == gb);
         assign bkp_word[gb] = word_reg;

         // Cleared only by the backup domain's own reset or a tamper erase, never by i_reset
         always_ff @(posedge i_ref_clk or posedge i_backup_reset)
         begin
            if (i_backup_reset)
            begin
               word_reg <= rsab_pkg::BKP_RESET;
            end
            else if (tamper_erase)
            begin
               // Erase beats a write in the same cycle, so no secret survives
               word_reg <= rsab_pkg::BKP_RESET;
            end
            else if (wr_sel)
            begin
               word_reg <= i_bus.wdata;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // Option, status, enable

   logic option_reg;
   logic [rsab_pkg::ST_W-1:0] status_reg;
   logic [rsab_pkg::ST_W-1:0] enable_reg;
   logic [rsab_pkg::DATA_W-1:0] rdata_reg;
   wire logic [rsab_pkg::ST_W-1:0] status_set;
   wire logic [rsab_pkg::ST_W-1:0] status_clr;
   wire logic [rsab_pkg::ST_W-1:0] status_next;
   wire logic alarm_level;

   assign status_set = {tamper_erase, alarm_hit[1], alarm_hit[0]};
   assign status_clr = (wr_en && sel_clear) ? i_bus.wdata[rsab_pkg::ST_W-1:0] : 3'h0;
   // Set wins over clear so no event is lost
   assign status_next = (status_reg & ~status_clr) | status_set;
   assign o_irq = |(status_reg & enable_reg);

   // Pin is active low; open-drain only sinks, push-pull drives both levels
   assign alarm_level = status_reg[rsab_pkg::ST_ALARM_A] || status_reg[rsab_pkg::ST_ALARM_B];
   assign o_alarm_pin_out = option_reg ? !alarm_level : 1'b0;
   assign o_alarm_pin_oe = option_reg ? 1'b1 : alarm_level;

   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         option_reg <= rsab_pkg::OPT_RESET;
         status_reg <= rsab_pkg::ST_RESET;
         enable_reg <= rsab_pkg::ST_RESET;
      end
      else
      begin
         if (wr_en && sel_option)
         begin
            option_reg <= i_bus.wdata[rsab_pkg::OPT_TYPE_BIT];
         end
         if (wr_en && sel_enable)
         begin
            enable_reg <= i_bus.wdata[rsab_pkg::ST_W-1:0];
         end
         status_reg <= status_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Read path

   wire logic [rsab_pkg::DATA_W-1:0] rd_mux;

   assign rd_mux = reg_hit(i_bus.addr, rsab_pkg::OFS_ALARM_A) ? alarm_rd[0]
                 : reg_hit(i_bus.addr, rsab_pkg::OFS_ALARM_B) ? alarm_rd[1]
                 : sel_option ? {31'h00000000, option_reg}
                 : sel_bkp ? bkp_word[bkp_idx]
                 : sel_status ? {29'h00000000, status_reg}
                 : sel_enable ? {29'h00000000, enable_reg}
                 : rsab_pkg::RD_IDLE;
   assign o_rdata = rdata_reg;

   // Data stand for one cycle only, zero otherwise
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         rdata_reg <= rsab_pkg::RD_IDLE;
      end
      else
      begin
         rdata_reg <= rd_en ? rd_mux : rsab_pkg::RD_IDLE;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_reset || i_backup_reset);

   sequence s_bkp0_write;
      wr_en && reg_hit(i_bus.addr, rsab_pkg::OFS_BKP_FIRST) && !tamper_erase;
   endsequence

   sequence s_bkp0_read;
      rd_en && reg_hit(i_bus.addr, rsab_pkg::OFS_BKP_FIRST) && !tamper_erase;
   endsequence

   a_tick_alarm_a: assert property (
      (alarm_mask[0] == 4'h0) && i_second_tick && i_fields_match[0]
      && !gen_alarm[0].cond_prev_reg |=> o_alarm_match[0])
      else $error("alarm A missed on seconds tick");

   a_tick_alarm_b: assert property (
      (alarm_mask[1] == 4'h0) && i_second_tick && i_fields_match[1]
      && !gen_alarm[1].cond_prev_reg |=> o_alarm_match[1])
      else $error("alarm B missed on seconds tick");

   a_masked_compare: assert property (
      (alarm_mask[0] != 4'h0) && i_fields_match[0] && !gen_alarm[0].cond_prev_reg
      && ((i_subsecond_sync_counter[14:0] << (15 - alarm_mask[0]))
          == (gen_alarm[0].alarm_reg.match_value << (15 - alarm_mask[0])))
      |=> o_alarm_match[0])
      else $error("masked sub-second match missed");

   a_full_compare: assert property (
      (alarm_mask[0] == 4'hF) && o_alarm_match[0] && !$past(i_second_tick)
      |-> $past(i_subsecond_sync_counter[14:0]) == $past(gen_alarm[0].alarm_reg.match_value))
      else $error("full compare flagged a mismatch");

   a_fields_gate: assert property (
      o_alarm_match[0] |-> $past(i_fields_match[0]))
      else $error("alarm without other fields matching");

   a_pin_type: assert property (
      (option_reg ? o_alarm_pin_oe : !o_alarm_pin_out)
      && (o_alarm_pin_oe || !alarm_level))
      else $error("alarm pin drive type wrong");

   a_bkp_readback: assert property (
      s_bkp0_write ##1 (s_bkp0_read and !wr_en) |=> o_rdata == $past(i_bus.wdata, 2))
      else $error("backup word read back wrong");

   a_tamper_erase: assert property (
      tamper_erase |=> (bkp_word[0] == 32'h00000000) && (bkp_word[BKP_WORDS-1] == 32'h00000000))
      else $error("tamper did not erase backup");

   a_tamper_keep: assert property (
      (i_tamper_event != 0) && !tamper_erase && !wr_en |=> $stable(bkp_word[0]))
      else $error("no-erase tamper changed backup");

   a_sysreset_keep: assert property (
      disable iff (i_backup_reset) i_reset && !wr_en |=> $stable(bkp_word[1]))
      else $error("system reset touched backup");

   a_status_irq: assert property (
      alarm_hit[0] && enable_reg[rsab_pkg::ST_ALARM_A] |=> o_irq)
      else $error("alarm A event lost on interrupt");

   // Bit 15 rolls over every second, so it must never gate a match
   a_top_bit_ignored: assert property (
      (alarm_mask[0] == 4'hF) && i_fields_match[0]
      && (i_subsecond_sync_counter[14:0] == gen_alarm[0].alarm_reg.match_value)
      |-> gen_alarm[0].cond)
      else $error("counter bit 15 spoiled a full match");

   a_tick_only: assert property (
      (alarm_mask[0] == 4'h0) && !i_second_tick |=> !o_alarm_match[0])
      else $error("mask zero alarm without seconds tick");

   a_mask_mismatch: assert property (
      (alarm_mask[0] != 4'h0)
      && (((i_subsecond_sync_counter[14:0] ^ gen_alarm[0].alarm_reg.match_value)
          << (15 - alarm_mask[0])) != 15'h0000)
      |=> !o_alarm_match[0])
      else $error("alarm on mismatch in compared bits");

   a_masked_compare_b: assert property (
      (alarm_mask[1] != 4'h0) && i_fields_match[1] && !gen_alarm[1].cond_prev_reg
      && ((i_subsecond_sync_counter[14:0] << (15 - alarm_mask[1]))
          == (gen_alarm[1].alarm_reg.match_value << (15 - alarm_mask[1])))
      |=> o_alarm_match[1])
      else $error("alarm B masked match missed");

   a_reset_subsec: assert property (
      $fell(i_reset) |-> (alarm_mask[0] == 4'h0) && (alarm_mask[1] == 4'h0)
      && (gen_alarm[0].alarm_reg.match_value == 15'h0000)
      && (gen_alarm[1].alarm_reg.match_value == 15'h0000))
      else $error("alarm sub-second register not cleared by reset");

   // Set wins over clear, so an event in the clearing cycle survives
   a_status_set: assert property (
      alarm_hit[0] |=> status_reg[rsab_pkg::ST_ALARM_A])
      else $error("alarm A event lost against a clear");

   a_erase_status: assert property (
      tamper_erase |=> status_reg[rsab_pkg::ST_ERASED])
      else $error("tamper erase not flagged");

   a_rdata_stands: assert property (
      !rd_en |=> (o_rdata == rsab_pkg::RD_IDLE))
      else $error("read data stood longer than one cycle");

endmodule // rsab_top
`default_nettype wire

//--- src/rsab_pkg.sv
`default_nettype none
package rsab_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int SS_W = 15;
   localparam int CNT_W = 16;
   localparam int MASK_W = 4;
   localparam int ALARM_NUM = 2;
   localparam int BKP_NUM = 20;
   localparam int TAMPER_NUM = 3;
   localparam int IDX_W = 5;
   localparam int ST_W = 3;
   // Register byte offsets
   localparam logic [7:0] OFS_ALARM_A = 8'h44;
   localparam logic [7:0] OFS_ALARM_B = 8'h48;
   localparam logic [7:0] OFS_OPTION = 8'h4C;
   localparam logic [7:0] OFS_BKP_FIRST = 8'h50;
   localparam logic [7:0] OFS_BKP_LAST = 8'h9C;
   localparam logic [7:0] OFS_STATUS = 8'hA0;
   localparam logic [7:0] OFS_CLEAR = 8'hA4;
   localparam logic [7:0] OFS_ENABLE = 8'hA8;
   // Field positions
   localparam int MASK_LSB = 24;
   localparam int MASK_MSB = 27;
   localparam int SSV_MSB = 14;
   localparam int OPT_TYPE_BIT = 0;
   localparam int ST_ALARM_A = 0;
   localparam int ST_ALARM_B = 1;
   localparam int ST_ERASED = 2;
   // Reset values
   localparam logic [MASK_W-1:0] MASK_RESET = 4'h0;
   localparam logic [SS_W-1:0] SSV_RESET = 15'h0000;
   localparam logic OPT_RESET = 1'b0;
   localparam logic [DATA_W-1:0] BKP_RESET = 32'h00000000;
   localparam logic [ST_W-1:0] ST_RESET = 3'h0;
   localparam logic [DATA_W-1:0] RD_IDLE = 32'h00000000;

   typedef struct packed
   {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } rsab_bus_req_type;

   typedef struct packed
   {
      logic [MASK_W-1:0] mask_count;
      logic [SS_W-1:0] match_value;
   } rsab_alarm_ss_type;
endpackage
`default_nettype wire

//--- testbench/rsab_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module rsab_top_tb;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic backup_reset = 1'b1;
   rsab_pkg::rsab_bus_req_type bus = '0;
   logic [31:0] rdata;
   logic [15:0] ss_count = 16'h0000;
   logic second_tick = 1'b0;
   logic [1:0] fields_match = 2'h0;
   logic [1:0] alarm_match;
   logic [2:0] tamper_event = 3'h0;
   logic [2:0] tamper_no_erase = 3'h7;
   logic pin_out;
   logic pin_oe;
   logic irq;
   int fails = 0;
   int checks = 0;

   always #5 ref_clk = ~ref_clk;

   rsab_top DUT
   (
      .i_ref_clk(ref_clk),
      .i_reset(reset),
      .i_backup_reset(backup_reset),
      .i_bus(bus),
      .o_rdata(rdata),
      .i_subsecond_sync_counter(ss_count),
      .i_second_tick(second_tick),
      .i_fields_match(fields_match),
      .o_alarm_match(alarm_match),
      .i_tamper_event(tamper_event),
      .i_tamper_no_erase(tamper_no_erase),
      .o_alarm_pin_out(pin_out),
      .o_alarm_pin_oe(pin_oe),
      .o_irq(irq)
   );

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict;
      if (fails == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // One idle cycle between accesses keeps each strobe assigned once per step
   task automatic bus_write(input logic [7:0] addr, input logic [31:0] data);
      @(posedge ref_clk);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
      @(posedge ref_clk);
      bus <= '0;
      #1;
   endtask

   task automatic read_check(input logic [7:0] addr, input logic [31:0] exp);
      @(posedge ref_clk);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 32'h00000000};
      @(posedge ref_clk);
      bus <= '0;
      #1;
      check(rdata, exp);
   endtask

   // Pulse must show one cycle after the condition and be gone the cycle after
   task automatic alarm_try(input int k, input logic [15:0] count, input logic tick,
                            input logic fld, input logic exp);
      @(posedge ref_clk);
      ss_count <= count;
      second_tick <= tick;
      fields_match[k] <= fld;
      @(posedge ref_clk);
      second_tick <= 1'b0;
      #1;
      check(alarm_match[k], exp);
      @(posedge ref_clk);
      fields_match[k] <= 1'b0;
      #1;
      check(alarm_match[k], 1'b0);
   endtask

   task automatic tamper_pulse(input int x, input logic keep);
      @(posedge ref_clk);
      tamper_no_erase[x] <= keep;
      tamper_event[x] <= 1'b1;
      @(posedge ref_clk);
      tamper_event <= 3'h0;
      tamper_no_erase <= 3'h7;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      logic [14:0] val;
      logic [14:0] lm;
      val = 15'h2D5A;
      repeat (5) @(posedge ref_clk);
      reset <= 1'b0;
      backup_reset <= 1'b0;
      read_check(rsab_pkg::OFS_ALARM_A, 32'h00000000);
      read_check(rsab_pkg::OFS_ALARM_B, 32'h00000000);
      read_check(rsab_pkg::OFS_OPTION, 32'h00000000);
      check(pin_oe, 1'b0);
      read_check(8'hB0, 32'h00000000);
      for (int i = 0; i < 20; i++)
         bus_write(8'h50 + 8'(4 * i), 32'hA5C30F00 ^ 32'(i));
      for (int i = 0; i < 20; i++)
         read_check(8'h50 + 8'(4 * i), 32'hA5C30F00 ^ 32'(i));
      // Reserved bits are always written as zero
      bus_write(rsab_pkg::OFS_ALARM_A, 32'h0F007FFF);
      read_check(rsab_pkg::OFS_ALARM_A, 32'h0F007FFF);
      bus_write(rsab_pkg::OFS_ALARM_B, 32'h0A001234);
      read_check(rsab_pkg::OFS_ALARM_B, 32'h0A001234);
      bus_write(rsab_pkg::OFS_OPTION, 32'h00000001);
      read_check(rsab_pkg::OFS_OPTION, 32'h00000001);
      // Mid-run system reset clears alarms and option, never the backup words
      @(posedge ref_clk);
      reset <= 1'b1;
      @(posedge ref_clk);
      reset <= 1'b0;
      for (int i = 0; i < 20; i++)
         read_check(8'h50 + 8'(4 * i), 32'hA5C30F00 ^ 32'(i));
      read_check(rsab_pkg::OFS_ALARM_A, 32'h00000000);
      read_check(rsab_pkg::OFS_ALARM_B, 32'h00000000);
      read_check(rsab_pkg::OFS_OPTION, 32'h00000000);
      // Write then read with no idle cycle between the strobes
      @(posedge ref_clk);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: rsab_pkg::OFS_BKP_FIRST, wdata: 32'hC0DE1234};
      @(posedge ref_clk);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: rsab_pkg::OFS_BKP_FIRST, wdata: 32'h00000000};
      @(posedge ref_clk);
      bus <= '0;
      #1;
      check(rdata, 32'hC0DE1234);
      for (int k = 0; k < 2; k++)
      begin
         for (int n = 0; n < 16; n++)
         begin
            bus_write((k == 0) ? rsab_pkg::OFS_ALARM_A : rsab_pkg::OFS_ALARM_B, {4'h0, 4'(n), 9'h000, val});
            lm = 15'h7FFF >> (15 - n);
            if (n == 0)
            begin
               alarm_try(k, {1'b1, ~val}, 1'b1, 1'b1, 1'b1);
               alarm_try(k, {1'b0, val}, 1'b0, 1'b1, 1'b0);
            end
            else
            begin
               alarm_try(k, {1'b1, val ^ ~lm}, 1'b0, 1'b1, 1'b1);
               alarm_try(k, {1'b0, val ^ (15'h0001 << (n - 1))}, 1'b0, 1'b1, 1'b0);
               alarm_try(k, {1'b0, val}, 1'b0, 1'b0, 1'b0);
            end
         end
      end
      bus_write(rsab_pkg::OFS_CLEAR, 32'hFFFFFFFF);
      read_check(rsab_pkg::OFS_STATUS, 32'h00000000);
      read_check(rsab_pkg::OFS_CLEAR, 32'h00000000);
      check(pin_oe, 1'b0);
      bus_write(rsab_pkg::OFS_ENABLE, 32'h00000001);
      read_check(rsab_pkg::OFS_ENABLE, 32'h00000001);
      alarm_try(0, {1'b0, val}, 1'b0, 1'b1, 1'b1);
      check(irq, 1'b1);
      check({pin_oe, pin_out}, 2'h2);
      read_check(rsab_pkg::OFS_STATUS, 32'h00000001);
      bus_write(rsab_pkg::OFS_OPTION, 32'h00000001);
      check({pin_oe, pin_out}, 2'h2);
      bus_write(rsab_pkg::OFS_CLEAR, 32'h00000001);
      check(irq, 1'b0);
      check({pin_oe, pin_out}, 2'h3);
      // Alarm B is not enabled, so its event must not reach the interrupt
      alarm_try(1, {1'b0, val}, 1'b0, 1'b1, 1'b1);
      check(irq, 1'b0);
      read_check(rsab_pkg::OFS_STATUS, 32'h00000002);
      bus_write(rsab_pkg::OFS_OPTION, 32'h00000000);
      for (int x = 0; x < 3; x++)
      begin
         bus_write(rsab_pkg::OFS_CLEAR, 32'hFFFFFFFF);
         bus_write(rsab_pkg::OFS_BKP_FIRST, 32'h13579BDF);
         bus_write(rsab_pkg::OFS_BKP_LAST, 32'h2468ACE0);
         tamper_pulse(x, 1'b1);
         read_check(rsab_pkg::OFS_BKP_FIRST, 32'h13579BDF);
         read_check(rsab_pkg::OFS_STATUS, 32'h00000000);
         tamper_pulse(x, 1'b0);
         read_check(rsab_pkg::OFS_BKP_FIRST, 32'h00000000);
         read_check(rsab_pkg::OFS_BKP_LAST, 32'h00000000);
         read_check(rsab_pkg::OFS_STATUS, 32'h00000004);
      end
      give_verdict();
   end
endmodule // rsab_top_tb
`default_nettype wire
